// ### core/dsb_pkg.sv
// constants and types shared by both ends of the two-word burst memory port
package dsb_pkg;
    localparam int DATA_W = 18;                  // data bus width, x18 variant
    localparam int ADDR_W = 8;                   // word address width of the model array
    localparam int LANES = 2;                    // byte-write lanes
    localparam int LANE_W = DATA_W / LANES;      // bits per lane
    localparam int DIV_HALF = 4;                 // system cycles per link clock half period
    localparam int NOP_CYCLES = 1024;            // idle link cycles before first operation
    localparam logic [10:0] NOP_CNT_RST = 11'h000;
    localparam logic [2:0] DIV_CNT_RST = 3'h0;
    typedef logic [DATA_W-1:0] dsb_data_t;
    typedef logic [ADDR_W-1:0] dsb_addr_t;
    typedef logic [LANES-1:0] dsb_lane_t;
    // controller link phase, gray on each step out of DSB_IDLE up to DSB_W2 or DSB_RWAIT, not on return to DSB_IDLE
    typedef enum logic [2:0] {
        DSB_INIT = 3'h0,
        DSB_IDLE = 3'h1,
        DSB_CMD = 3'h3,
        DSB_W1 = 3'h2,
        DSB_W2 = 3'h6,
        DSB_RWAIT = 3'h7
    } dsb_phase_e;
endpackage : dsb_pkg

// ### core/dsb_if.sv
// pin-level link between the memory device and its controller
`timescale 1ns/10ps
`default_nettype none
interface dsb_if;
    import dsb_pkg::*;
    logic clkPos;            // positive input clock
    logic clkNeg;            // negative input clock
    logic outClkPos;         // positive output clock
    logic outClkNeg;         // negative output clock
    logic cycleLoad_n;       // load, active low
    logic readNotWrite;      // high read, low write
    dsb_addr_t syncAddress;  // address, bit 0 is burst start lsb
    dsb_lane_t byteWrite_n;  // byte-write strobes, active low
    dsb_data_t dqCtl;        // controller drive
    logic dqCtlOe;           // controller drives bus
    dsb_data_t dqDev;        // device drive
    logic dqDevOe;           // device drives bus
    dsb_data_t dq;           // resolved bus level
    logic echoStrobePos;     // echo clock
    logic echoStrobeNeg;     // echo clock complement
    logic dllBypass_n;       // dll bypass, active low
    assign dq = dqDevOe ? dqDev : (dqCtlOe ? dqCtl : '0);
    modport device (input clkPos, clkNeg, outClkPos, outClkNeg, cycleLoad_n, readNotWrite,
        syncAddress, byteWrite_n, dq, dllBypass_n, output dqDev, dqDevOe, echoStrobePos, echoStrobeNeg);
    modport ctrl (output clkPos, clkNeg, outClkPos, outClkNeg, cycleLoad_n, readNotWrite,
        syncAddress, byteWrite_n, dqCtl, dqCtlOe, dllBypass_n, input dq, echoStrobePos, echoStrobeNeg);
endinterface : dsb_if
`default_nettype wire

// ### core/dsb_device.sv
// memory device end: samples link clocks, stores and returns two-word bursts
`timescale 1ns/10ps
`default_nettype none
// Contract
// R01: address and control taken on positive clock rise
// R02: write data taken on both clock rises
// R03: every transfer moves exactly two words
// R04: address lsb selects burst start word
// R05: address ignored while deselected
// R06: controller pulls load low for new cycle
// R07: read-write pin picks transfer direction
// R08: byte strobes sampled per word, low stores
// R09: read words follow negative then positive output clock
// R10: output clocks held high select input clocks
// R11: narrow variant starts bursts at even word
// R12: clock pairs ideally run in antiphase
// R13: echo clocks run freely, matched to data
// R14: dll bypass pin, 1024 idle cycles first
// R15: load high starts nothing, bus released
module dsb_device (
    // system
    input wire logic clk_sys,
    input wire logic rst,
    // link
    dsb_if.device link,
    // user side status
    output logic readActive,
    output logic dllBypassed
);
    import dsb_pkg::*;
    // two-flop synchronisers for every link input
    logic [4:0] clkS1_r, clkS2_r, clkS3_r;
    logic ctlS1_r, ctlS2_r, rwS1_r, rwS2_r, dllS1_r, dllS2_r;
    dsb_addr_t addrS1_r, addrS2_r;
    dsb_lane_t bwS1_r, bwS2_r;
    dsb_data_t dqS1_r, dqS2_r;
    dsb_data_t mem [2**ADDR_W];                  // storage array
    // transaction state
    logic busy_r, busy_nxt, isRead_r, isRead_nxt, second_r, second_nxt;
    dsb_addr_t addr_r, addr_nxt;
    dsb_data_t dqDev_r, dqDev_nxt;
    logic oe_r, oe_nxt;
    logic [1:0] rdWord_r, rdWord_nxt;            // read words still to send
    logic echo_r, echo_nxt;
    logic kRise, kbRise, cRise, cbRise, outRef, rdEdge1, rdEdge2;
    logic [1:0] wrLane;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            // idle pin levels: clkPos low, clkNeg high, output clocks and bypass high, so no false edge
            clkS1_r <= 5'h1E;
            clkS2_r <= 5'h1E;
            clkS3_r <= 5'h1E;
            {ctlS1_r, ctlS2_r, rwS1_r, rwS2_r} <= 4'hF;
            {dllS1_r, dllS2_r} <= 2'h3;
            addrS1_r <= '0;
            addrS2_r <= '0;
            bwS1_r <= '1;
            bwS2_r <= '1;
            dqS1_r <= '0;
            dqS2_r <= '0;
        end else begin
            clkS1_r <= {link.dllBypass_n, link.outClkNeg, link.outClkPos, link.clkNeg, link.clkPos};
            clkS2_r <= clkS1_r;
            clkS3_r <= clkS2_r;
            ctlS1_r <= link.cycleLoad_n;
            ctlS2_r <= ctlS1_r;
            rwS1_r <= link.readNotWrite;
            rwS2_r <= rwS1_r;
            dllS1_r <= link.dllBypass_n;
            dllS2_r <= dllS1_r;
            addrS1_r <= link.syncAddress;
            addrS2_r <= addrS1_r;
            bwS1_r <= link.byteWrite_n;
            bwS2_r <= bwS1_r;
            dqS1_r <= link.dq;
            dqS2_r <= dqS1_r;
        end
    end
    // edge detection on synchronised clocks only
    always_comb begin
        kRise = clkS2_r[0] && !clkS3_r[0];
        kbRise = clkS2_r[1] && !clkS3_r[1];
        cRise = clkS2_r[2] && !clkS3_r[2];
        cbRise = clkS2_r[3] && !clkS3_r[3];
        // output clocks held high fall back on input clocks
        outRef = !(clkS2_r[2] && clkS2_r[3]) ; // R10
        rdEdge1 = outRef ? cbRise : kbRise; // R09
        rdEdge2 = outRef ? cRise : kRise; // R09
    end
    // transaction sequencing and read drive
    always_comb begin
        busy_nxt = busy_r;
        isRead_nxt = isRead_r;
        second_nxt = second_r;
        addr_nxt = addr_r;
        dqDev_nxt = dqDev_r;
        oe_nxt = oe_r;
        rdWord_nxt = rdWord_r;
        echo_nxt = echo_r;
        wrLane = 2'h0;
        if (rdEdge1) echo_nxt = 1'b0; // R13
        if (rdEdge2) echo_nxt = 1'b1; // R13
        // write first word on the negative clock, second on next positive
        if (busy_r && !isRead_r && kbRise && !second_r) begin
            wrLane = ~bwS2_r; // R08
            second_nxt = 1'b1; // R02
        end else if (busy_r && !isRead_r && kRise && second_r) begin
            wrLane = ~bwS2_r; // R08
            busy_nxt = 1'b0; // R03
        end
        // read words leave on the reference edges
        if (rdWord_r == 2'h2 && rdEdge1) begin
            dqDev_nxt = mem[addr_r];
            oe_nxt = 1'b1; // R09
            rdWord_nxt = 2'h1;
        end else if (rdWord_r == 2'h1 && rdEdge2) begin
            dqDev_nxt = mem[{addr_r[ADDR_W-1:1], ~addr_r[0]}]; // R04
            rdWord_nxt = 2'h0; // R03
        end else if (rdWord_r == 2'h0 && rdEdge1 && oe_r) begin
            oe_nxt = 1'b0; // R15
        end
        // new cycle only on positive input clock with load low
        if (kRise && !ctlS2_r && !(busy_r && !isRead_r)) begin // R01 R05
            busy_nxt = !rwS2_r; // R07
            isRead_nxt = rwS2_r; // R07
            second_nxt = 1'b0;
            addr_nxt = addrS2_r; // R04
            if (rwS2_r) rdWord_nxt = 2'h2; // R07
        end
        // load high: address stays ignored and nothing starts
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_r <= 1'b0;
            isRead_r <= 1'b0;
            second_r <= 1'b0;
            addr_r <= '0;
            dqDev_r <= '0;
            oe_r <= 1'b0;
            rdWord_r <= 2'h0;
            echo_r <= 1'b0;
        end else begin
            busy_r <= busy_nxt;
            isRead_r <= isRead_nxt;
            second_r <= second_nxt;
            addr_r <= addr_nxt;
            dqDev_r <= dqDev_nxt;
            oe_r <= oe_nxt;
            rdWord_r <= rdWord_nxt;
            echo_r <= echo_nxt;
        end
    end
    // storage writes per lane; first word at loaded address, second at partner
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < LANES; i++) begin
            if (wrLane[i]) begin
                if (!second_r) mem[addr_r][i*LANE_W +: LANE_W] <= dqS2_r[i*LANE_W +: LANE_W];
                else mem[{addr_r[ADDR_W-1:1], ~addr_r[0]}][i*LANE_W +: LANE_W] <= dqS2_r[i*LANE_W +: LANE_W];
            end
        end
    end
    assign link.dqDev = dqDev_r;
    assign link.dqDevOe = oe_r; // R15
    assign link.echoStrobePos = echo_r; // R13
    assign link.echoStrobeNeg = ~echo_r; // R13
    assign readActive = oe_r;
    assign dllBypassed = !dllS2_r; // R14
endmodule : dsb_device
`default_nettype wire

// ### core/dsb_ctrl.sv
// controller end: makes link clocks, issues two-word bursts, returns read words through a two-entry buffer
`timescale 1ns/10ps
`default_nettype none
module dsb_ctrl (
    // system
    input wire logic clk_sys,
    input wire logic rst,
    // link
    dsb_if.ctrl link,
    // request side
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqRead,
    input wire dsb_pkg::dsb_addr_t reqAddr,
    input wire dsb_pkg::dsb_data_t reqData0,
    input wire dsb_pkg::dsb_data_t reqData1,
    input wire dsb_pkg::dsb_lane_t reqBw0_n,
    input wire dsb_pkg::dsb_lane_t reqBw1_n,
    // read data side
    output logic rdValid,
    input wire logic rdReady,
    output dsb_pkg::dsb_data_t rdData
);
    import dsb_pkg::*;
    logic [2:0] div_r, div_nxt;
    logic k_r, k_nxt, kRiseEn, midLowEn, midHighEn;
    logic [10:0] nop_r, nop_nxt;
    dsb_phase_e ph_r, ph_nxt;
    logic rd_r, rd_nxt, oe_r, oe_nxt, ld_r, ld_nxt;
    dsb_addr_t a_r, a_nxt;
    dsb_data_t d0_r, d0_nxt, d1_r, d1_nxt, dq_r, dq_nxt;
    dsb_lane_t b0_r, b0_nxt, b1_r, b1_nxt, bw_r, bw_nxt;
    logic [4:0] wait_r, wait_nxt;            // read capture counter
    dsb_data_t dqS1_r, dqS2_r;
    // two-entry read buffer
    dsb_data_t buf_r [2];
    logic [1:0] cnt_r, cnt_nxt;
    logic wp_r, wp_nxt, rp_r, rp_nxt, push;
    always_comb begin
        div_nxt = div_r + 3'h1;
        k_nxt = k_r;
        if (div_r == 3'(DIV_HALF - 1)) begin
            div_nxt = DIV_CNT_RST;
            k_nxt = ~k_r; // R12
        end
        kRiseEn = (div_r == 3'(DIV_HALF - 1)) && !k_r;
        // mid half-period launch points: a level launched on a link edge would be seen as new at that edge
        midLowEn = (div_r == 3'(DIV_HALF / 2 - 1)) && !k_r;
        midHighEn = (div_r == 3'(DIV_HALF / 2 - 1)) && k_r;
    end
    // command phase sequencing, load, data, strobe and enable changes fall midway between link clock rises
    always_comb begin
        ph_nxt = ph_r;
        nop_nxt = nop_r;
        rd_nxt = rd_r;
        oe_nxt = oe_r;
        ld_nxt = ld_r;
        a_nxt = a_r;
        d0_nxt = d0_r;
        d1_nxt = d1_r;
        b0_nxt = b0_r;
        b1_nxt = b1_r;
        dq_nxt = dq_r;
        bw_nxt = bw_r;
        wait_nxt = wait_r;
        push = 1'b0;
        reqReady = (ph_r == DSB_IDLE) && (cnt_r == 2'h0);
        if (ph_r == DSB_IDLE && reqValid && reqReady) begin
            ph_nxt = DSB_CMD;
            rd_nxt = reqRead;
            a_nxt = {reqAddr[ADDR_W-1:1], reqAddr[0]};
            d0_nxt = reqData0;
            d1_nxt = reqData1;
            b0_nxt = reqBw0_n;
            b1_nxt = reqBw1_n;
        end
        unique case (ph_r)
            DSB_INIT: begin
                if (kRiseEn) nop_nxt = nop_r + 11'h1;
                if (kRiseEn && nop_r == 11'(NOP_CYCLES - 1)) ph_nxt = DSB_IDLE; // R14
            end
            DSB_IDLE: begin
            end
            DSB_CMD: begin
                // load and first word settle before the positive rise that takes the command
                if (midLowEn) begin
                    ld_nxt = 1'b0; // R06
                    if (!rd_r) begin
                        dq_nxt = d0_r;
                        bw_nxt = b0_r; // R08
                        oe_nxt = 1'b1;
                    end
                    ph_nxt = rd_r ? DSB_RWAIT : DSB_W1;
                    wait_nxt = 5'h00;
                end
            end
            DSB_W1: begin
                // load released after the command rise; first word held across the negative rise
                if (midHighEn) ld_nxt = 1'b1;
                if (midLowEn) begin
                    dq_nxt = d1_r; // R02
                    bw_nxt = b1_r; // R08
                    ph_nxt = DSB_W2;
                end
            end
            DSB_W2: begin
                // second word held across the positive rise, then bus released
                if (midHighEn) begin
                    oe_nxt = 1'b0;
                    bw_nxt = '1;
                    ph_nxt = DSB_IDLE; // R03
                end
            end
            DSB_RWAIT: begin
                if (midHighEn) ld_nxt = 1'b1;
                wait_nxt = wait_r + 5'h01;
                // capture points sit mid-way in each word's window behind the device and local sync delay
                if (wait_r == 5'h0C || wait_r == 5'h10) push = 1'b1; // R03
                if (wait_r == 5'h10) ph_nxt = DSB_IDLE;
            end
            default: ph_nxt = DSB_INIT;
        endcase
    end
    always_comb begin
        cnt_nxt = cnt_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        if (push) begin
            wp_nxt = ~wp_r;
            cnt_nxt = cnt_nxt + 2'h1;
        end
        if (rdValid && rdReady) begin
            rp_nxt = ~rp_r;
            cnt_nxt = cnt_nxt - 2'h1;
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_r <= DIV_CNT_RST;
            k_r <= 1'b0;
            nop_r <= NOP_CNT_RST;
            ph_r <= DSB_INIT;
            rd_r <= 1'b0;
            oe_r <= 1'b0;
            ld_r <= 1'b1;
            a_r <= '0;
            d0_r <= '0;
            d1_r <= '0;
            b0_r <= '1;
            b1_r <= '1;
            dq_r <= '0;
            bw_r <= '1;
            wait_r <= 5'h00;
            dqS1_r <= '0;
            dqS2_r <= '0;
            cnt_r <= 2'h0;
            wp_r <= 1'b0;
            rp_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            k_r <= k_nxt;
            nop_r <= nop_nxt;
            ph_r <= ph_nxt;
            rd_r <= rd_nxt;
            oe_r <= oe_nxt;
            ld_r <= ld_nxt;
            a_r <= a_nxt;
            d0_r <= d0_nxt;
            d1_r <= d1_nxt;
            b0_r <= b0_nxt;
            b1_r <= b1_nxt;
            dq_r <= dq_nxt;
            bw_r <= bw_nxt;
            wait_r <= wait_nxt;
            dqS1_r <= link.dq;
            dqS2_r <= dqS1_r;
            cnt_r <= cnt_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end
    // buffer storage holds no control state, so no reset
    always_ff @(posedge clk_sys) begin
        if (push) buf_r[wp_r] <= dqS2_r;
    end
    assign rdValid = cnt_r != 2'h0;
    assign rdData = buf_r[rp_r];
    assign link.clkPos = k_r;
    assign link.clkNeg = ~k_r;
    // output clocks held high: input clocks time reads
    assign link.outClkPos = 1'b1; // R10
    assign link.outClkNeg = 1'b1; // R10
    assign link.cycleLoad_n = ld_r;
    assign link.readNotWrite = rd_r;
    assign link.syncAddress = a_r;
    assign link.byteWrite_n = bw_r;
    assign link.dqCtl = dq_r;
    assign link.dqCtlOe = oe_r;
    assign link.dllBypass_n = 1'b1;
endmodule : dsb_ctrl
`default_nettype wire

// ### verification/dsb_link_monitor.sv
// concurrent checks on the link between memory device and controller
`timescale 1ns/10ps
`default_nettype none
module dsb_link_monitor (
    // system
    input wire logic clk_sys,
    input wire logic rst,
    // link clocks
    input wire logic clkPos,
    input wire logic clkNeg,
    input wire logic outClkPos,
    input wire logic outClkNeg,
    // command and bus enables
    input wire logic cycleLoad_n,
    input wire logic readNotWrite,
    input wire dsb_pkg::dsb_addr_t syncAddress,
    input wire logic dqCtlOe,
    input wire logic dqDevOe,
    // device status pins
    input wire logic echoStrobePos,
    input wire logic dllBypass_n
);
    import dsb_pkg::*;
    logic [5:0] sinceRd_r; // age of the last read command, saturating
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // commands as the device sees them at a positive clock rise
    sequence readCmd;
        $rose(clkPos) && !cycleLoad_n && readNotWrite;
    endsequence
    sequence writeCmd;
        $rose(clkPos) && !cycleLoad_n && !readNotWrite;
    endsequence
    // saturates so a stray drive long after a read is still caught
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sinceRd_r <= 6'h3F;
        end else if ($rose(clkPos) && !cycleLoad_n && readNotWrite) begin
            sinceRd_r <= 6'h00;
        end else if (sinceRd_r != 6'h3F) begin
            sinceRd_r <= sinceRd_r + 6'h01;
        end
    end
    clk_pair_a: assert property (clkNeg == !clkPos)
        else $error("link clocks not in antiphase");
    out_clk_held_a: assert property (outClkPos && outClkNeg)
        else $error("output clocks not held high");
    dll_enabled_a: assert property (dllBypass_n)
        else $error("dll bypass pin asserted");
    one_driver_a: assert property (!(dqDevOe && dqCtlOe))
        else $error("both ends drive the data bus");
    ctl_stable_a: assert property ($rose(clkPos) && !cycleLoad_n |-> $stable(syncAddress) && $stable(readNotWrite)
        && $stable(cycleLoad_n))
        else $error("command moved at positive clock rise");
    read_answer_a: assert property (readCmd |-> ##[2:24] dqDevOe)
        else $error("read command drew no data");
    write_quiet_a: assert property (writeCmd |-> !dqDevOe [*8])
        else $error("device drove bus during write");
    burst_len_a: assert property ($rose(dqDevOe) |-> ##[2:16] !dqDevOe)
        else $error("read burst overran two words");
    drive_window_a: assert property (dqDevOe |-> sinceRd_r < 6'h20)
        else $error("device drove bus with no read pending");
    echo_run_a: assert property (1'b1 |-> ##[1:12] $changed(echoStrobePos))
        else $error("echo clock stopped");
endmodule : dsb_link_monitor
`default_nettype wire

// ### verification/tb.sv
// self-checking bench: controller and device joined over the link
`timescale 1ns/10ps
`default_nettype none
module tb;
    import dsb_pkg::*;
    // one burst request as a table row
    typedef struct {logic rd; dsb_addr_t a; dsb_data_t d0; dsb_data_t d1; dsb_lane_t b0; dsb_lane_t b1;} dsb_row_s;
    logic clk_sys, rst, reqValid, reqReady, reqRead, rdValid, rdReady, readActive, dllBypassed;
    dsb_addr_t reqAddr;
    dsb_data_t reqData0, reqData1, rdData;
    dsb_lane_t reqBw0_n, reqBw1_n;
    int failures = 0;
    int compares = 0;
    int cyc = 0;
    dsb_data_t mem [0:255]; // bench copy of what the array should hold
    dsb_data_t w [2];
    // writes odd and even starts back to back, a partial-lane write, then a write with no lanes
    dsb_row_s rows [8] = '{
        '{1'b0, 8'h10, 18'h12345, 18'h2ABCD, 2'h0, 2'h0}, '{1'b1, 8'h10, 18'h0, 18'h0, 2'h3, 2'h3},
        '{1'b0, 8'h21, 18'h0AAAA, 18'h15555, 2'h0, 2'h0}, '{1'b0, 8'h20, 18'h3C3C3, 18'h0F0F0, 2'h2, 2'h1},
        '{1'b1, 8'h20, 18'h0, 18'h0, 2'h3, 2'h3}, '{1'b1, 8'h21, 18'h0, 18'h0, 2'h3, 2'h3},
        '{1'b0, 8'h10, 18'h00000, 18'h3FFFF, 2'h3, 2'h3}, '{1'b1, 8'h11, 18'h0, 18'h0, 2'h3, 2'h3}};
    dsb_if lnk();
    dsb_device i_dsb_device (.clk_sys(clk_sys), .rst(rst), .link(lnk), .readActive(readActive),
        .dllBypassed(dllBypassed));
    dsb_ctrl i_dsb_ctrl (.clk_sys(clk_sys), .rst(rst), .link(lnk), .reqValid(reqValid), .reqReady(reqReady),
        .reqRead(reqRead), .reqAddr(reqAddr), .reqData0(reqData0), .reqData1(reqData1), .reqBw0_n(reqBw0_n),
        .reqBw1_n(reqBw1_n), .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData));
    dsb_link_monitor i_dsb_link_monitor (.clk_sys(clk_sys), .rst(rst), .clkPos(lnk.clkPos), .clkNeg(lnk.clkNeg),
        .outClkPos(lnk.outClkPos), .outClkNeg(lnk.outClkNeg), .cycleLoad_n(lnk.cycleLoad_n),
        .readNotWrite(lnk.readNotWrite), .syncAddress(lnk.syncAddress), .dqCtlOe(lnk.dqCtlOe),
        .dqDevOe(lnk.dqDevOe), .echoStrobePos(lnk.echoStrobePos), .dllBypass_n(lnk.dllBypass_n));
    // 25 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // init alone takes about 8200 cycles, so the ceiling leaves ample room
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            close_out();
        end
    end
    task automatic close_out();
        if (failures == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    task automatic chk_data(input string name, input dsb_data_t exp, input dsb_data_t got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_data
    task automatic chk_bit(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit
    // hold the request until the controller takes it
    task automatic issue(input dsb_row_s r);
        int n;
        n = 0;
        reqRead <= r.rd;
        reqAddr <= r.a;
        reqData0 <= r.d0;
        reqData1 <= r.d1;
        reqBw0_n <= r.b0;
        reqBw1_n <= r.b1;
        reqValid <= 1'b1;
        // ready is looked at mid-cycle, where it is settled; the take is the next rise
        @(negedge clk_sys);
        while (reqReady !== 1'b1 && n < 20000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 20000) failures++;
        @(posedge clk_sys);
        reqValid <= 1'b0;
    endtask : issue
    // ready stays high across both words so it is never set twice in one step
    task automatic getpair();
        int n;
        rdReady <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            @(negedge clk_sys);
            while (rdValid !== 1'b1 && n < 100) begin
                @(negedge clk_sys);
                n++;
            end
            if (n >= 100) failures++;
            w[k] = rdData;
            // the word leaves the buffer at this rise
            @(posedge clk_sys);
        end
        rdReady <= 1'b0;
    endtask : getpair
    // one row: reads compare both words, writes update the copy lane by lane
    task automatic run(input dsb_row_s r);
        issue(r);
        if (r.rd) begin
            getpair();
            chk_data("word0", mem[r.a], w[0]);
            chk_data("word1", mem[r.a ^ 8'h01], w[1]);
        end else begin
            for (int l = 0; l < LANES; l++) begin
                if (!r.b0[l]) mem[r.a][l*LANE_W +: LANE_W] = r.d0[l*LANE_W +: LANE_W];
                if (!r.b1[l]) mem[r.a ^ 8'h01][l*LANE_W +: LANE_W] = r.d1[l*LANE_W +: LANE_W];
            end
            repeat (24) @(posedge clk_sys);
            chk_bit("readActive", 1'b0, readActive);
        end
    endtask : run
    initial begin
        rst = 1'b1;
        {reqValid, reqRead, rdReady} = 3'h0;
        reqAddr = '0;
        {reqData0, reqData1} = '0;
        {reqBw0_n, reqBw1_n} = 4'hF;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rows[i]) run(rows[i]);
        chk_bit("dllBypassed", 1'b0, dllBypassed);
        // receiver stalls: both words must wait in the buffer
        issue(rows[5]);
        repeat (40) @(posedge clk_sys);
        chk_bit("rdValid", 1'b1, rdValid);
        getpair();
        chk_data("stall word0", mem[8'h21], w[0]);
        chk_data("stall word1", mem[8'h20], w[1]);
        // reset in mid-read: bus released and init restarts
        issue(rows[1]);
        for (int k = 0; k < 40 && readActive !== 1'b1; k++) @(posedge clk_sys);
        chk_bit("readActive before reset", 1'b1, readActive);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk_bit("devOe", 1'b0, lnk.dqDevOe);
        chk_bit("readActive", 1'b0, readActive);
        rst <= 1'b0;
        repeat (40) @(posedge clk_sys);
        chk_bit("reqReady", 1'b0, reqReady);
        close_out();
    end
endmodule : tb
`default_nettype wire
